// file: src/pio_parallel_io_ports_defs.vh
`ifndef PIO_PARALLEL_IO_PORTS_DEFS_VH
`define PIO_PARALLEL_IO_PORTS_DEFS_VH

// Bus address width and register index width
`define PIO_ADDR_W 8
`define PIO_IDX_W 6
`define PIO_IDX_LSB 2

// Register indices, byte address is four times the index
`define PIO_IDX_PORT_A 6'h00
`define PIO_IDX_PORT_B 6'h01
`define PIO_IDX_PORT_C 6'h02
`define PIO_IDX_PORT_D 6'h03
`define PIO_IDX_DIR_A 6'h04
`define PIO_IDX_DIR_B 6'h05
`define PIO_IDX_DIR_C 6'h06
`define PIO_IDX_CLK_CTL 6'h07
`define PIO_IDX_ADC_DATA 6'h08
`define PIO_IDX_ADC_CTL 6'h09

// Field positions
`define PIO_CLK_OUT_BIT 3
`define PIO_CONV_ON_BIT 5
`define PIO_CLK_PIN 2

// Reset values
`define PIO_DIR_RST 8'h00
`define PIO_BIT_RST 1'b0

// Bus answers and lanes
`define PIO_RESP_OKAY 2'b00
`define PIO_RESP_SLVERR 2'b10
`define PIO_STRB_LOW 0

`endif

// file: src/pio_parallel_io_ports.v
// Function
// - Three bidirectional bytes plus one input-only byte
// - Direction one drives pin, zero listens
// - Reset clears all direction registers
// - Direction registers read back what was written
// - Output bits read back the latch
// - Input bits read back the pin
// - Write to output bit drives pin at once
// - Write to input bit still loads latch
// - Data latches keep value through reset
// - Clock enable bit puts clock on C2
// - Clock output forces C2 output, reads latch
// - Other port C pins stay normal
// - Reset clears clock enable, so does a write with bit 3 low
// - Input-only port never drives pins
// - Converter on makes input pins analog
// - Reset turns converter off
// - Input-only port readable at any time
// - Converter-on bit selects input pin function
`timescale 1ns/100ps
`include "pio_parallel_io_ports_defs.vh"

module pio_parallel_io_ports
(
   input wire aclk, // Clock
   input wire aresetn, // Synchronous reset, low
   input wire ce, // Clock enable
   input wire [`PIO_ADDR_W-1:0] s_axi_awaddr, // Write address
   input wire [2:0] s_axi_awprot, // Write protection, unused
   input wire s_axi_awvalid, // Write address valid
   output wire s_axi_awready, // Write address ready
   input wire [31:0] s_axi_wdata, // Write data
   input wire [3:0] s_axi_wstrb, // Write strobes
   input wire s_axi_wvalid, // Write data valid
   output wire s_axi_wready, // Write data ready
   output wire [1:0] s_axi_bresp, // Write response
   output wire s_axi_bvalid, // Write response valid
   input wire s_axi_bready, // Write response ready
   input wire [`PIO_ADDR_W-1:0] s_axi_araddr, // Read address
   input wire [2:0] s_axi_arprot, // Read protection, unused
   input wire s_axi_arvalid, // Read address valid
   output wire s_axi_arready, // Read address ready
   output wire [31:0] s_axi_rdata, // Read data
   output wire [1:0] s_axi_rresp, // Read response
   output wire s_axi_rvalid, // Read data valid
   input wire s_axi_rready, // Read data ready
   input wire [7:0] port_a_in, // Port A pin level
   output wire [7:0] port_a_out, // Port A pin drive value
   output wire [7:0] port_a_oe, // Port A drive enable
   input wire [7:0] port_b_in, // Port B pin level
   output wire [7:0] port_b_out, // Port B pin drive value
   output wire [7:0] port_b_oe, // Port B drive enable
   input wire [7:0] port_c_in, // Port C pin level
   output wire [7:0] port_c_out, // Port C pin drive value
   output wire [7:0] port_c_oe, // Port C drive enable
   input wire [7:0] input_only_pins, // Input-only port levels
   output wire converter_on, // Input-only pins given to converter
   output wire internal_bus_clock // Bus clock seen on C2
);

   // Pin synchronisers
   reg [7:0] pa_s1_r;
   reg [7:0] pa_s2_r;
   reg [7:0] pb_s1_r;
   reg [7:0] pb_s2_r;
   reg [7:0] pc_s1_r;
   reg [7:0] pc_s2_r;
   reg [7:0] pd_s1_r;
   reg [7:0] pd_s2_r;

   // Port state
   reg [7:0] port_a_data_r;
   reg [7:0] port_b_data_r;
   reg [7:0] port_c_data_r;
   reg [7:0] direction_bit_a_r;
   reg [7:0] direction_bit_b_r;
   reg [7:0] direction_bit_c_r;
   reg clock_out_enable_r;
   reg converter_on_r;
   reg bus_clk_r;

   // Bus slave state
   reg aw_full_r;
   reg w_full_r;
   reg [`PIO_ADDR_W-1:0] aw_addr_r;
   reg [7:0] w_byte_r;
   reg w_low_r;
   reg bvalid_r;
   reg [1:0] bresp_r;
   reg rvalid_r;
   reg [1:0] rresp_r;
   reg [7:0] rdata_r;

   wire [`PIO_IDX_W-1:0] wr_idx;
   wire [`PIO_IDX_W-1:0] rd_idx;
   wire wr_fire;
   wire wr_en;
   wire rd_fire;
   wire [7:0] clk_mask;
   wire [7:0] dir_c_eff;
   reg [7:0] rd_byte;

   // Register index from a byte address
   function [`PIO_IDX_W-1:0] pio_index;
      input [`PIO_ADDR_W-1:0] addr;
      begin
         pio_index = addr[`PIO_ADDR_W-1:`PIO_IDX_LSB];
      end
   endfunction

   // Index names a register of this block
   function pio_mapped;
      input [`PIO_IDX_W-1:0] idx;
      begin
         pio_mapped = (idx <= `PIO_IDX_ADC_CTL) && (idx != `PIO_IDX_ADC_DATA);
      end
   endfunction

   // Per-bit choice of latch or pin
   function [7:0] pio_pin_read;
      input [7:0] dir;
      input [7:0] latch;
      input [7:0] pin;
      begin
         pio_pin_read = (dir & latch) | (~dir & pin);
      end
   endfunction

   // Two flops on every pin before use
   always @(posedge aclk)
   begin
      if (ce)
      begin
         pa_s1_r <= port_a_in;
         pa_s2_r <= pa_s1_r;
         pb_s1_r <= port_b_in;
         pb_s2_r <= pb_s1_r;
         pc_s1_r <= port_c_in;
         pc_s2_r <= pc_s1_r;
         pd_s1_r <= input_only_pins;
         pd_s2_r <= pd_s1_r;
      end
   end

   // Bus handshakes
   assign s_axi_awready = ce & aresetn & ~aw_full_r;
   assign s_axi_wready = ce & aresetn & ~w_full_r;
   assign s_axi_arready = ce & aresetn & ~rvalid_r;
   assign wr_fire = ce & aw_full_r & w_full_r & ~bvalid_r;
   assign rd_fire = s_axi_arvalid & s_axi_arready;
   assign wr_idx = pio_index(aw_addr_r);
   assign rd_idx = pio_index(s_axi_araddr);
   assign wr_en = wr_fire & w_low_r & pio_mapped(wr_idx);

   // Write address and data captured in either order
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         aw_addr_r <= {`PIO_ADDR_W{1'b0}};
         w_byte_r <= 8'h00;
         w_low_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= `PIO_RESP_OKAY;
      end
      else if (ce)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_full_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_full_r <= 1'b1;
            w_byte_r <= s_axi_wdata[7:0];
            w_low_r <= s_axi_wstrb[`PIO_STRB_LOW];
         end
         if (wr_fire)
         begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= pio_mapped(wr_idx) ? `PIO_RESP_OKAY : `PIO_RESP_SLVERR;
         end
         else if (bvalid_r && s_axi_bready)
         begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // Data latches load on every write with strobe bit 0 set, whatever the direction
   always @(posedge aclk)
   begin
      if (wr_en)
      begin
         case (wr_idx)
            `PIO_IDX_PORT_A: port_a_data_r <= w_byte_r;
            `PIO_IDX_PORT_B: port_b_data_r <= w_byte_r;
            `PIO_IDX_PORT_C: port_c_data_r <= w_byte_r;
            default: ;
         endcase
      end
   end

   // Direction and control registers
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         direction_bit_a_r <= `PIO_DIR_RST;
         direction_bit_b_r <= `PIO_DIR_RST;
         direction_bit_c_r <= `PIO_DIR_RST;
         clock_out_enable_r <= `PIO_BIT_RST;
         converter_on_r <= `PIO_BIT_RST;
      end
      else if (wr_en)
      begin
         case (wr_idx)
            `PIO_IDX_DIR_A: direction_bit_a_r <= w_byte_r;
            `PIO_IDX_DIR_B: direction_bit_b_r <= w_byte_r;
            `PIO_IDX_DIR_C: direction_bit_c_r <= w_byte_r;
            `PIO_IDX_CLK_CTL: clock_out_enable_r <= w_byte_r[`PIO_CLK_OUT_BIT];
            `PIO_IDX_ADC_CTL: converter_on_r <= w_byte_r[`PIO_CONV_ON_BIT];
            default: ;
         endcase
      end
   end

   // Bus clock copy that runs with the block
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bus_clk_r <= 1'b0;
      end
      else if (ce)
      begin
         bus_clk_r <= ~bus_clk_r;
      end
   end

   // Clock output forces only pin two of port C
   assign clk_mask = {{(7-`PIO_CLK_PIN){1'b0}}, clock_out_enable_r, {`PIO_CLK_PIN{1'b0}}};
   assign dir_c_eff = direction_bit_c_r | clk_mask;

   // Register read mux
   always @*
   begin
      rd_byte = 8'h00;
      case (rd_idx)
         `PIO_IDX_PORT_A: rd_byte = pio_pin_read(direction_bit_a_r, port_a_data_r, pa_s2_r);
         `PIO_IDX_PORT_B: rd_byte = pio_pin_read(direction_bit_b_r, port_b_data_r, pb_s2_r);
         `PIO_IDX_PORT_C: rd_byte = pio_pin_read(dir_c_eff, port_c_data_r, pc_s2_r);
         `PIO_IDX_PORT_D: rd_byte = pd_s2_r;
         `PIO_IDX_DIR_A: rd_byte = direction_bit_a_r;
         `PIO_IDX_DIR_B: rd_byte = direction_bit_b_r;
         `PIO_IDX_DIR_C: rd_byte = direction_bit_c_r;
         `PIO_IDX_CLK_CTL: rd_byte[`PIO_CLK_OUT_BIT] = clock_out_enable_r;
         `PIO_IDX_ADC_CTL: rd_byte[`PIO_CONV_ON_BIT] = converter_on_r;
         default: rd_byte = 8'h00;
      endcase
   end

   // Read answer one cycle after the address is taken
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_r <= 1'b0;
         rresp_r <= `PIO_RESP_OKAY;
         rdata_r <= 8'h00;
      end
      else if (ce)
      begin
         if (rd_fire)
         begin
            rvalid_r <= 1'b1;
            rdata_r <= pio_mapped(rd_idx) ? rd_byte : 8'h00;
            rresp_r <= pio_mapped(rd_idx) ? `PIO_RESP_OKAY : `PIO_RESP_SLVERR;
         end
         else if (rvalid_r && s_axi_rready)
         begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // Bus outputs
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = {24'h000000, rdata_r};

   // Pin drive, latch straight to pin except C2 while clock output is on
   assign port_a_out = port_a_data_r;
   assign port_a_oe = direction_bit_a_r;
   assign port_b_out = port_b_data_r;
   assign port_b_oe = direction_bit_b_r;
   assign port_c_out = (port_c_data_r & ~clk_mask) | ({8{bus_clk_r}} & clk_mask);
   assign port_c_oe = dir_c_eff;

   // Input-only port has no drive; converter takes its pins
   assign converter_on = converter_on_r;
   assign internal_bus_clock = bus_clk_r;

endmodule // pio_parallel_io_ports

// file: dv/pio_pins_model.sv
`timescale 1ns/100ps
// Board side of one port: drives a pin only where the block does not
module pio_pins_model
(
   input wire [7:0] out_v, // Block value
   input wire [7:0] oe, // Block enable
   input wire [7:0] ext_v, // Board value
   output wire [7:0] level // Pin level
);
   // Block wins where it drives, board elsewhere
   assign level = (oe & out_v) | (~oe & ext_v);
endmodule // pio_pins_model

// file: dv/pio_ports_chk.sv
`timescale 1ns/100ps
// Watches bus answers and pin drive of the port block
module pio_ports_chk
(
   input wire aclk, // Clock
   input wire aresetn, // Reset
   input wire ce, // Enable
   input wire s_axi_awvalid, // Aw valid
   input wire s_axi_wvalid, // W valid
   input wire s_axi_arvalid, // Ar valid
   input wire s_axi_arready, // Ar ready
   input wire s_axi_bvalid, // B valid
   input wire s_axi_bready, // B ready
   input wire [31:0] s_axi_rdata, // R data
   input wire s_axi_rvalid, // R valid
   input wire [7:0] port_a_oe, // A enable
   input wire [7:0] port_b_oe, // B enable
   input wire [7:0] port_c_oe, // C enable
   input wire [7:0] port_c_out, // C value
   input wire converter_on, // Converter
   input wire internal_bus_clock // Bus clock
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Reset state
   dir_reset_a: assert property (disable iff (1'b0) !aresetn && ce |=> (port_a_oe | port_b_oe | port_c_oe) == 8'h00)
      else $error("drive enable set after reset");
   conv_reset_a: assert property (disable iff (1'b0) !aresetn && ce |=> !converter_on)
      else $error("converter on after reset");
   // Clock output and C2 drive
   clk_toggle_a: assert property (ce |=> internal_bus_clock != $past(internal_bus_clock))
      else $error("bus clock stalled");
   c2_forced_a: assert property ($rose(port_c_out[2]) ##1 $fell(port_c_out[2]) ##1 $rose(port_c_out[2]) |-> port_c_oe[2])
      else $error("clock on C2 without drive");
   // Directions of ports A and B only move on a write
   dir_keep_a: assert property (!s_axi_awvalid && !s_axi_wvalid && !$past(s_axi_awvalid) && !$past(s_axi_wvalid)
      |=> $stable(port_a_oe) && $stable(port_b_oe))
      else $error("direction moved without write");
   // Bus answers
   b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");
   r_late_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
      else $error("read answer late or wide");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("second read taken");
endmodule // pio_ports_chk
bind pio_parallel_io_ports pio_ports_chk u_chk (.aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_wvalid, .s_axi_arvalid,
   .s_axi_arready, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .port_a_oe, .port_b_oe, .port_c_oe,
   .port_c_out, .converter_on, .internal_bus_clock);

// file: dv/pio_parallel_io_ports_tb_top.sv
`timescale 1ns/100ps
`include "pio_parallel_io_ports_defs.vh"
// Register bus tests of the port block against a board model
module pio_parallel_io_ports_tb_top;
   logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, awr, wr, bv, arr, rv, bc, cv;
   logic [7:0] aa = 0, ra = 0, din = 8'h5a;
   logic [31:0] wd = 0, rd, q;
   logic [1:0] bz, rz, r;
   logic [7:0] ext [3], lv [3], po [3], oe [3];
   int error_cnt = 0, checks_done = 0, i;
   // Clock
   always #2 aclk = ~aclk;
   pio_parallel_io_ports dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(aa), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wr), .s_axi_bresp(bz), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ra),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rz),
      .s_axi_rvalid(rv), .s_axi_rready(rr), .port_a_in(lv[0]), .port_a_out(po[0]), .port_a_oe(oe[0]),
      .port_b_in(lv[1]), .port_b_out(po[1]), .port_b_oe(oe[1]), .port_c_in(lv[2]), .port_c_out(po[2]),
      .port_c_oe(oe[2]), .input_only_pins(din), .converter_on(cv), .internal_bus_clock(bc));
   pio_pins_model pa (.out_v(po[0]), .oe(oe[0]), .ext_v(ext[0]), .level(lv[0]));
   pio_pins_model pb (.out_v(po[1]), .oe(oe[1]), .ext_v(ext[1]), .level(lv[1]));
   pio_pins_model pc (.out_v(po[2]), .oe(oe[2]), .ext_v(ext[2]), .level(lv[2]));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // One bus transfer, write when w is high; answer taken at the edge that shows it
   task automatic xfer(input logic w, input logic [5:0] ix, input logic [7:0] d);
      logic a, b, e, c;
      int n;
      n = 0;
      c = 0;
      @(posedge aclk);
      aa <= {ix, 2'h0};
      ra <= {ix, 2'h0};
      wd <= {24'h0, d};
      awv <= w;
      wv <= w;
      br <= w;
      arv <= !w;
      rr <= !w;
      while (!c && n < 40)
      begin
         @(posedge aclk);
         n++;
         a = awv & awr;
         b = wv & wr;
         e = arv & arr;
         c = w ? (bv & br) : (rv & rr);
         if (a) awv <= 0;
         if (b) wv <= 0;
         if (e) arv <= 0;
         if (c)
         begin
            q = rd;
            r = w ? bz : rz;
            br <= 0;
            rr <= 0;
         end
      end
      if (!c) error_cnt++;
      if (!c) report_and_stop();
   endtask
   task automatic put(input logic [5:0] ix, input logic [7:0] d);
      xfer(1, ix, d);
      chk({30'h0, r}, {30'h0, `PIO_RESP_OKAY});
   endtask
   task automatic get(input logic [5:0] ix, input logic [31:0] exp);
      xfer(0, ix, 8'h0);
      chk({30'h0, r}, {30'h0, `PIO_RESP_OKAY});
      chk(q, exp);
   endtask
   task automatic rst;
      @(posedge aclk);
      aresetn <= 0;
      repeat (5) @(posedge aclk);
      aresetn <= 1;
   endtask
   // Main sequence
   initial
   begin
      ext[0] = 8'h3c;
      ext[1] = 8'hc3;
      ext[2] = 8'h00;
      rst();
      for (i = 0; i < 3; i++) get(6'(i + 4), 32'h0);
      get(`PIO_IDX_CLK_CTL, 32'h0);
      get(`PIO_IDX_ADC_CTL, 32'h0);
      $display("reset test done");
      for (i = 0; i < 3; i++)
      begin
         put(6'(i), 8'ha5);
         chk({24'h0, oe[i]}, 32'h0);
         get(6'(i), {24'h0, ext[i]});
         put(6'(i + 4), 8'hf0);
         get(6'(i + 4), 32'hf0);
         chk({16'h0, oe[i], po[i]}, 32'hf0a5);
         get(6'(i), {24'h0, 4'ha, ext[i][3:0]});
      end
      $display("port test done");
      put(`PIO_IDX_CLK_CTL, 8'h08);
      get(`PIO_IDX_CLK_CTL, 32'h08);
      chk({24'h0, oe[2]}, 32'hf4);
      get(`PIO_IDX_PORT_C, 32'ha4);
      @(negedge aclk);
      q = {31'h0, po[2][2]};
      chk(q, {31'h0, bc});
      @(negedge aclk);
      chk({31'h0, po[2][2]}, ~q & 32'h1);
      $display("clock out test done");
      rst();
      chk({24'h0, po[0]}, 32'ha5);
      chk({16'h0, oe[0], oe[2]}, 32'h0);
      get(`PIO_IDX_CLK_CTL, 32'h0);
      $display("second reset test done");
      put(`PIO_IDX_ADC_CTL, 8'h20);
      chk({31'h0, cv}, 32'h1);
      get(`PIO_IDX_ADC_CTL, 32'h20);
      put(`PIO_IDX_PORT_D, 8'hff);
      get(`PIO_IDX_PORT_D, {24'h0, din});
      xfer(0, 6'h08, 8'h0);
      chk({30'h0, r}, {30'h0, `PIO_RESP_SLVERR});
      chk(q, 32'h0);
      $display("input port test done");
      report_and_stop();
   end
endmodule // pio_parallel_io_ports_tb_top
